//--- hw/tlp_pkg.sv
// Purpose: Shared constants of the packet classifier.
// Assumes: Byte offsets as seen on the register access port.
// Notes:   Widths and codes follow the packet header layout.
package tlp_pkg;
    // ****************************************
    // Format and type codes
    // ****************************************
    localparam logic [1:0] FMT_3DW_ND = 2'h0;
    localparam logic [1:0] FMT_4DW_ND = 2'h1;
    localparam logic [1:0] FMT_3DW_D  = 2'h2;
    localparam logic [1:0] FMT_4DW_D  = 2'h3;
    localparam int         FMT_DATA   = 1;
    localparam logic [4:0] TY_MEM     = 5'h00;
    localparam logic [4:0] TY_MEM_LK  = 5'h01;
    localparam logic [4:0] TY_IO      = 5'h02;
    localparam logic [4:0] TY_CFG0    = 5'h04;
    localparam logic [4:0] TY_CFG1    = 5'h05;
    localparam logic [4:0] TY_CPL     = 5'h0a;
    localparam logic [4:0] TY_CPL_LK  = 5'h0b;
    localparam logic [1:0] TY_MSG_HI  = 2'h2;
    localparam logic [1:0] TY_ASW_HI  = 2'h3;
    localparam logic [2:0] TC_ZERO    = 3'h0;
    localparam logic [9:0] MAX_PAY_DW = 10'h040;
    localparam logic [9:0] LEN_ZERO   = 10'h000;
    // ****************************************
    // Route classes and classified word layout
    // ****************************************
    localparam logic [1:0] RT_NONE = 2'h0;
    localparam logic [1:0] RT_ADDR = 2'h1;
    localparam logic [1:0] RT_ID   = 2'h2;
    localparam logic [1:0] RT_IMPL = 2'h3;
    localparam int CW_W    = 22;
    localparam int CW_MAL  = 21;
    localparam int CW_UNS  = 20;
    localparam int CW_RT   = 18;
    localparam int CW_DST  = 15;
    localparam int CW_HIT  = 14;
    localparam int CW_D4   = 13;
    localparam int CW_TC   = 10;
    // ****************************************
    // Register offsets and fields
    // ****************************************
    localparam logic [9:0] CF_HDR    = 10'h00c;
    localparam logic [9:0] CF_CTL40  = 10'h040;
    localparam logic [9:0] CF_SCSR   = 10'h054;
    localparam logic [9:0] CF_WIN1   = 10'h058;
    localparam logic [9:0] CF_MEM2   = 10'h05f;
    localparam logic [9:0] CF_MEM3   = 10'h063;
    localparam logic [9:0] CF_CAP    = 10'h0b0;
    localparam logic [9:0] CF_VITC   = 10'h0c0;
    localparam logic [9:0] CF_M0XB   = 10'h0e0;
    localparam logic [9:0] CF_M0SU   = 10'h0e4;
    localparam logic [9:0] CF_W1XB   = 10'h0e8;
    localparam logic [9:0] CF_W1SU   = 10'h0ec;
    localparam logic [9:0] CS_TIDX   = 10'h050;
    localparam logic [9:0] CS_TDAT   = 10'h054;
    localparam logic [9:0] CS_TBL    = 10'h100;
    localparam logic [1:0] CS_TBL_HI = 2'h1;
    localparam int         VI_EN_BIT = 26;
    localparam int         WIN_LO    = 12;
    localparam logic [7:0] HT_TYPE1  = 8'h01;
    localparam logic [7:0] HT_TYPE0  = 8'h00;
    localparam logic [3:0] PT_FWD    = 4'h7;
    localparam logic [3:0] PT_REV    = 4'h8;
    localparam logic [3:0] CAP_VER   = 4'h1;
    localparam logic [7:0] CAP_ID    = 8'h10;
    localparam logic [7:0] CAP_NEXT  = 8'h00;
    localparam int         TBL_N     = 64;
endpackage

//--- hw/tlp_classifier.sv
// Purpose: Classify incoming packets and hold bridge personality registers.
// Assumes: Header fields arrive from logic on the same clock.
// Notes:   Classified words queue in a FIFO toward the forwarding side.
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Shift FIFO
// ****************************************
module cls_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int NW = $clog2(D + 1);
    typedef struct packed {
        logic [D-1:0][W-1:0] m;
        logic [NW-1:0]       n;
        logic                rdy;
        logic                vld;
    } fifo_t;
    fifo_t f_reg;
    fifo_t f_next;
    logic  push;
    logic  pop;
    logic [NW-1:0] wp;

    assign push      = in_valid & f_reg.rdy;
    assign pop       = f_reg.vld & out_ready;
    assign in_ready  = f_reg.rdy;
    assign out_valid = f_reg.vld;
    assign out_data  = f_reg.m[0];
    // Shifting costs more flops than a ring, but the head always sits in one register.

    always_comb begin
        f_next = f_reg;
        wp = f_reg.n - NW'(pop);
        if (pop) begin
            for (int i = 0; i < D - 1; i++) begin
                f_next.m[i] = f_reg.m[i+1];
            end
        end
        if (push) begin
            f_next.m[wp] = in_data;
        end
        f_next.n   = f_reg.n + NW'(push) - NW'(pop);
        f_next.rdy = f_next.n != NW'(D);
        f_next.vld = f_next.n != '0;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            f_reg     <= '0;
            f_reg.rdy <= 1'b1;
        end else begin
            f_reg <= f_next;
        end
    end

    // A word that is not taken must stay at the head unchanged.
    AST_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("Queued word lost before it was taken.");
endmodule

// ****************************************
// Classifier top
// ****************************************
module tlp_classifier #(
    parameter int FIFO_D = 16
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        bridge_direction_strap,
    input  wire logic        bridge_mode_strap,
    input  wire logic        hdr_valid,
    output logic             hdr_ready,
    input  wire logic [1:0]  hdr_fmt,
    input  wire logic [4:0]  hdr_type,
    input  wire logic [2:0]  hdr_tc,
    input  wire logic [9:0]  hdr_len,
    input  wire logic        hdr_has_data,
    input  wire logic [31:0] hdr_addr,
    output logic             cls_valid,
    input  wire logic        cls_ready,
    output logic [21:0]      cls_word,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_csr,
    input  wire logic [9:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    output logic             reg_ack,
    output logic             vi_enabled,
    output logic [2:0]       upstream_tc,
    output logic             transparent
);
    localparam int TBL_W = tlp_pkg::TBL_N * 32;
    typedef struct packed {
        logic [1:0]        dir_s;
        logic [1:0]        mode_s;
        logic [31:0]       ctl40;
        logic [31:0]       vitc;
        logic [3:0][31:0]  bar;
        logic [3:0][31:0]  xlat;
        logic [5:0]        tidx;
        logic [TBL_W-1:0]  tbl;
        logic [31:0]       rdata;
        logic              ack;
        logic              vi_en;
        logic [2:0]        up_tc;
        logic              transp;
    } st_t;
    st_t s_reg;
    st_t s_next;
    logic [tlp_pkg::CW_W-1:0] cw;
    logic [1:0] rt;
    logic [2:0] dst;
    logic mal;
    logic uns;
    logic hit;
    logic is_mem;
    logic is_cfg;
    logic is_io;
    logic is_msg;
    logic [3:0] ptype;
    logic [7:0] htype;
    logic [31:0] rd;
    logic [5:0] ti;

    // ****************************************
    // Header decode
    // ****************************************
    assign is_mem = hdr_type == tlp_pkg::TY_MEM || hdr_type == tlp_pkg::TY_MEM_LK;
    assign is_io  = hdr_type == tlp_pkg::TY_IO;
    assign is_cfg = hdr_type == tlp_pkg::TY_CFG0 || hdr_type == tlp_pkg::TY_CFG1;
    assign is_msg = hdr_type[4:3] == tlp_pkg::TY_MSG_HI;

    always_comb begin
        rt  = tlp_pkg::RT_NONE;
        dst = '0;
        hit = 1'b0;
        uns = 1'b0;
        if (is_mem || is_io) begin
            rt = tlp_pkg::RT_ADDR;
            // Only address-routed kinds look at the windows, so a stray match
            // cannot mark a configuration or message packet as a window hit.
            for (int i = 0; i < 4; i++) begin
                if (hdr_addr[31:tlp_pkg::WIN_LO] == s_reg.bar[i][31:tlp_pkg::WIN_LO]) begin
                    hit = 1'b1;
                    dst = 3'(i);
                end
            end
        end else if (is_cfg || hdr_type == tlp_pkg::TY_CPL
                     || hdr_type == tlp_pkg::TY_CPL_LK) begin
            rt  = tlp_pkg::RT_ID;
        end else if (is_msg) begin
            rt  = tlp_pkg::RT_IMPL;
            dst = hdr_type[2:0];
        end else begin
            uns = 1'b1;
        end
        mal = 1'b0;
        if (hdr_has_data != hdr_fmt[tlp_pkg::FMT_DATA]) begin
            mal = 1'b1;
        end
        if (hdr_fmt[tlp_pkg::FMT_DATA]
            && (hdr_len == tlp_pkg::LEN_ZERO || hdr_len > tlp_pkg::MAX_PAY_DW)) begin
            mal = 1'b1;
        end
        // Memory packets never fail on class: they always go across.
        if ((is_cfg || is_io || is_msg) && hdr_tc != tlp_pkg::TC_ZERO) begin
            mal = 1'b1;
        end
        cw = {mal, uns, rt, dst, hit, hdr_fmt[0], hdr_tc, hdr_len};
    end

    cls_fifo #(
        .W (tlp_pkg::CW_W),
        .D (FIFO_D)
    ) u_fifo (
        .clock     (clock),
        .arst_n    (arst_n),
        .in_valid  (hdr_valid),
        .in_ready  (hdr_ready),
        .in_data   (cw),
        .out_valid (cls_valid),
        .out_ready (cls_ready),
        .out_data  (cls_word)
    );

    // ****************************************
    // Registers
    // ****************************************
    assign ptype = s_reg.dir_s[1] ? tlp_pkg::PT_REV : tlp_pkg::PT_FWD;
    assign htype = s_reg.mode_s[1] ? tlp_pkg::HT_TYPE0 : tlp_pkg::HT_TYPE1;
    assign ti    = reg_addr[7:2];

    always_comb begin
        s_next        = s_reg;
        s_next.dir_s  = {s_reg.dir_s[0], bridge_direction_strap};
        s_next.mode_s = {s_reg.mode_s[0], bridge_mode_strap};
        s_next.ack    = reg_rd;
        rd            = '0;
        if (!reg_csr) begin
            case (reg_addr)
                tlp_pkg::CF_HDR:   rd = {8'h00, htype, 16'h0000};
                tlp_pkg::CF_CTL40: rd = s_reg.ctl40;
                tlp_pkg::CF_CAP:   rd = {8'h00, ptype, tlp_pkg::CAP_VER,
                                         tlp_pkg::CAP_NEXT, tlp_pkg::CAP_ID};
                tlp_pkg::CF_VITC:  rd = s_reg.vitc;
                tlp_pkg::CF_SCSR:  rd = s_reg.bar[0];
                tlp_pkg::CF_WIN1:  rd = s_reg.bar[1];
                tlp_pkg::CF_MEM2:  rd = s_reg.bar[2];
                tlp_pkg::CF_MEM3:  rd = s_reg.bar[3];
                tlp_pkg::CF_M0XB:  rd = s_reg.xlat[0];
                tlp_pkg::CF_M0SU:  rd = s_reg.xlat[1];
                tlp_pkg::CF_W1XB:  rd = s_reg.xlat[2];
                tlp_pkg::CF_W1SU:  rd = s_reg.xlat[3];
                default:           rd = '0;
            endcase
            if (reg_wr) begin
                case (reg_addr)
                    tlp_pkg::CF_CTL40: s_next.ctl40   = reg_wdata;
                    tlp_pkg::CF_VITC:  s_next.vitc    = reg_wdata;
                    tlp_pkg::CF_SCSR:  s_next.bar[0]  = reg_wdata;
                    tlp_pkg::CF_WIN1:  s_next.bar[1]  = reg_wdata;
                    tlp_pkg::CF_MEM2:  s_next.bar[2]  = reg_wdata;
                    tlp_pkg::CF_MEM3:  s_next.bar[3]  = reg_wdata;
                    tlp_pkg::CF_M0XB:  s_next.xlat[0] = reg_wdata;
                    tlp_pkg::CF_M0SU:  s_next.xlat[1] = reg_wdata;
                    tlp_pkg::CF_W1XB:  s_next.xlat[2] = reg_wdata;
                    tlp_pkg::CF_W1SU:  s_next.xlat[3] = reg_wdata;
                    default:           s_next.ctl40   = s_reg.ctl40;
                endcase
            end
        end else if (reg_addr[9:8] == tlp_pkg::CS_TBL_HI) begin
            rd = s_reg.tbl[ti*32 +: 32];
            if (reg_wr) begin
                s_next.tbl[ti*32 +: 32] = reg_wdata;
            end
        end else if (reg_addr == tlp_pkg::CS_TIDX) begin
            rd = {26'h0, s_reg.tidx};
            if (reg_wr) begin
                s_next.tidx = reg_wdata[5:0];
            end
        end else if (reg_addr == tlp_pkg::CS_TDAT) begin
            rd = s_reg.tbl[s_reg.tidx*32 +: 32];
            if (reg_wr) begin
                s_next.tbl[s_reg.tidx*32 +: 32] = reg_wdata;
            end
        end
        s_next.rdata  = reg_rd ? rd : '0;
        s_next.vi_en  = s_next.ctl40[tlp_pkg::VI_EN_BIT];
        // Upstream class stays zero until the mode is turned on.
        s_next.up_tc  = s_next.vi_en ? s_next.vitc[2:0] : tlp_pkg::TC_ZERO;
        s_next.transp = !s_reg.mode_s[1];
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata   = s_reg.rdata;
    assign reg_ack     = s_reg.ack;
    assign vi_enabled  = s_reg.vi_en;
    assign upstream_tc = s_reg.up_tc;
    assign transparent = s_reg.transp;

    // ****************************************
    // Checks
    // ****************************************
    sequence cap_read;
        reg_rd && !reg_csr && reg_addr == tlp_pkg::CF_CAP;
    endsequence
    sequence switch_hdr;
        hdr_valid && hdr_type[4:3] == tlp_pkg::TY_ASW_HI;
    endsequence
    sequence tbl_read;
        reg_rd && reg_csr && reg_addr[9:8] == tlp_pkg::CS_TBL_HI;
    endsequence
    sequence idx_write;
        reg_wr && reg_csr && reg_addr == tlp_pkg::CS_TIDX;
    endsequence

    AST_FMT: assert property (@(posedge clock) disable iff (!arst_n)
        hdr_valid && hdr_has_data != hdr_fmt[1] |-> cw[tlp_pkg::CW_MAL])
        else $error("Format mismatch not flagged.");
    AST_LEN: assert property (@(posedge clock) disable iff (!arst_n)
        hdr_valid && hdr_fmt[1] && hdr_len > 10'h040 |-> cw[tlp_pkg::CW_MAL])
        else $error("Oversize payload not flagged.");
    AST_ADDR: assert property (@(posedge clock) disable iff (!arst_n)
        hdr_valid && (is_mem || is_io) |-> rt == tlp_pkg::RT_ADDR)
        else $error("Memory or I/O not address routed.");
    AST_ID: assert property (@(posedge clock) disable iff (!arst_n)
        hdr_valid && is_cfg |-> rt == tlp_pkg::RT_ID)
        else $error("Config not ID routed.");
    AST_MSG: assert property (@(posedge clock) disable iff (!arst_n)
        hdr_valid && is_msg |-> rt == tlp_pkg::RT_IMPL && dst == hdr_type[2:0])
        else $error("Message route wrong.");
    AST_TC: assert property (@(posedge clock) disable iff (!arst_n)
        hdr_valid && (is_cfg || is_io || is_msg) && hdr_tc != tlp_pkg::TC_ZERO |-> mal)
        else $error("Nonzero class not flagged.");
    AST_MEM: assert property (@(posedge clock) disable iff (!arst_n)
        hdr_valid && is_mem && hdr_has_data == hdr_fmt[1] && !hdr_fmt[1] |-> !mal)
        else $error("Memory packet wrongly malformed.");
    AST_VI: assert property (@(posedge clock) disable iff (!arst_n)
        reg_wr && !reg_csr && reg_addr == tlp_pkg::CF_CTL40 && reg_wdata[26]
        |=> vi_enabled && upstream_tc == s_reg.vitc[2:0])
        else $error("Isochronous enable not taken.");
    AST_PT: assert property (@(posedge clock) disable iff (!arst_n)
        cap_read ##0 $stable(s_reg.dir_s[1])
        |=> reg_ack && reg_rdata[23:20] == (s_reg.dir_s[1] ? 4'h8 : 4'h7)
            && reg_rdata[19:16] == 4'h1)
        else $error("Port type or version wrong.");
    AST_HT: assert property (@(posedge clock) disable iff (!arst_n)
        reg_rd && !reg_csr && reg_addr == tlp_pkg::CF_HDR ##0 $stable(s_reg.mode_s[1])
        |=> reg_rdata[23:16] == (s_reg.mode_s[1] ? 8'h00 : 8'h01))
        else $error("Header type wrong.");
    AST_UNS: assert property (@(posedge clock) disable iff (!arst_n)
        switch_hdr |-> cw[tlp_pkg::CW_UNS] && rt == tlp_pkg::RT_NONE)
        else $error("Switching packet not marked unsupported.");
    AST_WIN: assert property (@(posedge clock) disable iff (!arst_n)
        hdr_valid && !is_mem && !is_io |-> !hit)
        else $error("Window hit on a packet not routed by address.");
    // The straps reach the mode only through the synchroniser, so the mode lags the pin.
    AST_TP: assert property (@(posedge clock) disable iff (!arst_n)
        !s_reg.mode_s[1] |=> transparent)
        else $error("Transparent mode not shown.");
    AST_NT: assert property (@(posedge clock) disable iff (!arst_n)
        s_reg.mode_s[1] |=> !transparent)
        else $error("Non-transparent mode not shown.");
    AST_VIOFF: assert property (@(posedge clock) disable iff (!arst_n)
        !vi_enabled |-> upstream_tc == tlp_pkg::TC_ZERO)
        else $error("Upstream class set while isochronous mode is off.");
    AST_UPTC: assert property (@(posedge clock) disable iff (!arst_n)
        vi_enabled |-> upstream_tc == s_reg.vitc[2:0])
        else $error("Upstream class does not follow its control bits.");
    AST_TBL: assert property (@(posedge clock) disable iff (!arst_n)
        tbl_read |=> reg_ack)
        else $error("Table read not answered.");
    AST_IDX: assert property (@(posedge clock) disable iff (!arst_n)
        idx_write |=> s_reg.tidx == 6'($past(reg_wdata)))
        else $error("Table index not taken.");
endmodule
`default_nettype wire

//--- tb/link_partner.sv
// Purpose: Model of the link partner that feeds packet headers to the classifier.
// Assumes: Headers are queued by the bench through the send task.
// Notes:   Fields that are not offered change every cycle.
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Header source
// ****************************************
module link_partner (
    input  wire logic        clock,
    input  wire logic        arst_n,
    output logic             hdr_valid,
    input  wire logic        hdr_ready,
    output logic [1:0]       hdr_fmt,
    output logic [4:0]       hdr_type,
    output logic [2:0]       hdr_tc,
    output logic [9:0]       hdr_len,
    output logic             hdr_has_data,
    output logic [31:0]      hdr_addr
);
    logic [52:0] pend[$];
    logic [52:0] cur;
    task automatic send(input logic [52:0] h);
        pend.push_back(h);
    endtask
    assign {hdr_fmt, hdr_type, hdr_tc, hdr_len, hdr_has_data, hdr_addr} = cur;
    // A header is held until the edge that finds ready high.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hdr_valid <= 1'b0;
            cur <= '0;
        end else if (!hdr_valid || hdr_ready) begin
            if (pend.size() > 0) begin
                hdr_valid <= 1'b1;
                cur <= pend.pop_front();
            end else begin
                hdr_valid <= 1'b0;
                cur <= ~cur;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench of the packet classifier.
// Assumes: Register, strap and ready inputs change at the falling edge; header inputs change at the rising edge.
// Notes:   All headers use an address inside window one.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        dir_s = 1'b0, mode_s = 1'b0, cls_ready = 1'b0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, reg_csr = 1'b0;
    logic [9:0]  reg_addr = 10'h000;
    logic [31:0] reg_wdata = 32'h0000_0000, rd;
    logic        hdr_valid, hdr_ready, hdr_has_data, cls_valid, reg_ack, vi_enabled, transparent;
    logic [1:0]  hdr_fmt;
    logic [4:0]  hdr_type;
    logic [2:0]  hdr_tc, upstream_tc;
    logic [9:0]  hdr_len;
    logic [31:0] hdr_addr, reg_rdata;
    logic [21:0] cls_word;
    int          n_errors = 0, num_checks = 0, cycles = 0;
    always #25 clock = ~clock;
    link_partner i_link_partner (.clock(clock), .arst_n(arst_n), .hdr_valid(hdr_valid),
        .hdr_ready(hdr_ready), .hdr_fmt(hdr_fmt), .hdr_type(hdr_type), .hdr_tc(hdr_tc),
        .hdr_len(hdr_len), .hdr_has_data(hdr_has_data), .hdr_addr(hdr_addr));
    tlp_classifier #(.FIFO_D(16)) i_tlp_classifier (.clock(clock), .arst_n(arst_n),
        .bridge_direction_strap(dir_s), .bridge_mode_strap(mode_s), .hdr_valid(hdr_valid),
        .hdr_ready(hdr_ready), .hdr_fmt(hdr_fmt), .hdr_type(hdr_type), .hdr_tc(hdr_tc),
        .hdr_len(hdr_len), .hdr_has_data(hdr_has_data), .hdr_addr(hdr_addr),
        .cls_valid(cls_valid), .cls_ready(cls_ready), .cls_word(cls_word), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_csr(reg_csr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .vi_enabled(vi_enabled),
        .upstream_tc(upstream_tc), .transparent(transparent));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_access(input logic wr, input logic csr, input logic [9:0] a,
                              input logic [31:0] wd);
        @(negedge clock);
        reg_wr = wr;
        reg_rd = !wr;
        reg_csr = csr;
        reg_addr = a;
        reg_wdata = wd;
        @(negedge clock);
        rd = reg_rdata;
        if (!wr) check("read ack", {31'h0, reg_ack}, 32'h1);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask
    // Expected classified word, worked out from the header fields alone.
    function automatic logic [21:0] exp_word(input logic [20:0] h);
        logic [1:0] f;
        logic [4:0] t;
        logic [2:0] c;
        logic [9:0] l;
        logic d, m, u, ad, im;
        logic [1:0] rt;
        {f, t, c, l, d} = h;
        u = (t[4:3] == 2'b11);
        im = (t[4:3] == 2'b10);
        ad = (t == tlp_pkg::TY_MEM || t == tlp_pkg::TY_IO);
        m = (d != f[1]) || (d && (l == 10'h000 || l > 10'h040)) ||
            ((t == tlp_pkg::TY_CFG0 || t == tlp_pkg::TY_CFG1 || t == tlp_pkg::TY_IO || im) &&
             c != 3'h0);
        rt = u ? 2'h0 : ad ? 2'h1 : im ? 2'h3 : 2'h2;
        return {m, u, rt, im ? t[2:0] : ad ? 3'h1 : 3'h0, ad, f[0], c, l};
    endfunction
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_reset();
        check("hdr_ready", {31'h0, hdr_ready}, 32'h1);
        check("cls_valid", {31'h0, cls_valid}, 32'h0);
        check("vi_enabled", {31'h0, vi_enabled}, 32'h0);
        check("upstream_tc", {29'h0, upstream_tc}, 32'h0);
    endtask
    task automatic sc_straps();
        for (int k = 0; k < 4; k++) begin
            @(negedge clock);
            dir_s = k[0];
            mode_s = k[1];
            repeat (3) @(negedge clock);
            reg_access(1'b0, 1'b0, tlp_pkg::CF_CAP, 32'h0);
            check("cap", rd, {8'h00, k[0] ? tlp_pkg::PT_REV : tlp_pkg::PT_FWD, 4'h1, 16'h0010});
            reg_access(1'b0, 1'b0, tlp_pkg::CF_HDR, 32'h0);
            check("hdr type", rd & 32'h00ff_0000, {8'h00, k[1] ? 8'h00 : 8'h01, 16'h0});
            check("transparent", {31'h0, transparent}, {31'h0, !k[1]});
        end
        mode_s = 1'b0;
        dir_s = 1'b0;
    endtask
    task automatic sc_isoch();
        reg_access(1'b1, 1'b0, tlp_pkg::CF_VITC, 32'h0000_0005);
        check("tc off", {29'h0, upstream_tc}, 32'h0);
        reg_access(1'b1, 1'b0, tlp_pkg::CF_CTL40, 32'h0400_0000);
        check("vi on", {31'h0, vi_enabled}, 32'h1);
        for (int t = 1; t < 8; t++) begin
            reg_access(1'b1, 1'b0, tlp_pkg::CF_VITC, t);
            check("tc on", {29'h0, upstream_tc}, t);
        end
    endtask
    task automatic sc_table();
        for (int k = 0; k < 64; k += 63) begin
            reg_access(1'b1, 1'b1, 10'h100 + 10'(4 * k), 32'ha5a5_0000 | k);
            reg_access(1'b1, 1'b1, tlp_pkg::CS_TIDX, k);
            reg_access(1'b0, 1'b1, tlp_pkg::CS_TDAT, 32'h0);
            check("table via index", rd, 32'ha5a5_0000 | k);
        end
        reg_access(1'b1, 1'b1, tlp_pkg::CS_TIDX, 32'h8);
        reg_access(1'b1, 1'b1, tlp_pkg::CS_TDAT, 32'h5a5a_0008);
        reg_access(1'b0, 1'b1, 10'h120, 32'h0);
        check("table direct", rd, 32'h5a5a_0008);
        reg_access(1'b0, 1'b0, 10'h3fc, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask
    // Fills the FIFO past its depth with the far side stalled, then drains it in order.
    task automatic sc_classify();
        logic [20:0] tbl[17];
        int w;
        tbl = '{{2'h0, 5'h00, 3'h0, 10'd1, 1'b0}, {2'h1, 5'h00, 3'h5, 10'd1, 1'b0},
                {2'h2, 5'h00, 3'h0, 10'd64, 1'b1}, {2'h3, 5'h00, 3'h0, 10'd1, 1'b1},
                {2'h2, 5'h00, 3'h0, 10'd65, 1'b1}, {2'h2, 5'h00, 3'h0, 10'd0, 1'b1},
                {2'h0, 5'h00, 3'h0, 10'd1, 1'b1}, {2'h2, 5'h02, 3'h0, 10'd1, 1'b1},
                {2'h2, 5'h02, 3'h1, 10'd1, 1'b1}, {2'h0, 5'h04, 3'h0, 10'd1, 1'b0},
                {2'h0, 5'h05, 3'h3, 10'd1, 1'b0}, {2'h1, 5'h14, 3'h0, 10'd1, 1'b0},
                {2'h1, 5'h13, 3'h2, 10'd1, 1'b0}, {2'h1, 5'h1a, 3'h0, 10'd1, 1'b0},
                {2'h1, 5'h00, 3'h7, 10'd1, 1'b0}, {2'h2, 5'h00, 3'h0, 10'd2, 1'b1},
                {2'h0, 5'h00, 3'h0, 10'd3, 1'b0}};
        reg_access(1'b1, 1'b0, tlp_pkg::CF_WIN1, 32'h1234_5000);
        foreach (tbl[i]) i_link_partner.send({tbl[i], 32'h1234_5abc});
        repeat (30) @(negedge clock);
        check("full refuses", {31'h0, hdr_ready}, 32'h0);
        cls_ready = 1'b1;
        foreach (tbl[i]) begin
            w = 0;
            while (cls_valid !== 1'b1 && w < 50) begin
                @(negedge clock);
                w++;
            end
            check("cls valid", {31'h0, cls_valid}, 32'h1);
            check("cls word", {10'h0, cls_word}, {10'h0, exp_word(tbl[i])});
            @(negedge clock);
        end
        cls_ready = 1'b0;
        repeat (3) @(negedge clock);
        check("drained", {31'h0, cls_valid}, 32'h0);
    endtask
    // ****************************************
    // Main sequence and time limit
    // ****************************************
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(negedge clock);
        arst_n = 1'b1;
        @(negedge clock);
        sc_reset();
        sc_straps();
        sc_isoch();
        sc_table();
        sc_classify();
        complete_run();
    end
endmodule
`default_nettype wire
